// file: common/hcr_map.svh
`ifndef HCR_MAP_SVH
`define HCR_MAP_SVH

// Register byte addresses
`define HCR_HWCFG_OFFSET 32'h0000_0074
`define HCR_IRQ_STATUS_OFFSET 32'h0000_0100
`define HCR_IRQ_CLEAR_OFFSET 32'h0000_0104
`define HCR_IRQ_ENABLE_OFFSET 32'h0000_0108

// Hardware configuration field positions
`define HCR_XOVER_STRAP_BIT 24
`define HCR_MBO_BIT 20
`define HCR_ALLOC_MSB 19
`define HCR_ALLOC_LSB 16
`define HCR_BUS_WIDTH_BIT 2
`define HCR_TIMEOUT_BIT 1
`define HCR_SOFT_RESET_TRIGGER_BIT 0
`define HCR_RSVD_MASK 32'hfee0_fff8

// Reset values
`define HCR_ALLOC_RESET 4'h5
`define HCR_MBO_RESET 1'b0

// Interrupt status layout
`define HCR_IRQ_DONE_BIT 0
`define HCR_IRQ_TIMEOUT_BIT 1
`define HCR_IRQ_WIDTH 2

// Memory split, in bytes
`define HCR_TX_STATUS_BYTES 15'h0200
`define HCR_TOTAL_BYTES 15'h4000

// Bus answers
`define HCR_RESP_OKAY 2'h0
`define HCR_RESP_DECERR 2'h3

// Timing
`define HCR_CLK_PERIOD_NS 4
`define HCR_SOFT_RESET_TRIGGER_TIMEOUT_NS 10000
`define HCR_SOFT_RESET_TRIGGER_PULSE_NS 32

`endif

// file: common/hcr_pkg.sv
`default_nettype none

package hcr_pkg;

	typedef logic [14:0] hcr_bytes_t;

	typedef enum logic [2:0] {
		SR_IDLE = 3'h1,
		SR_WAIT = 3'h2,
		SR_PULSE = 3'h4
	} hcr_soft_reset_trigger_t;

	typedef struct packed {
		logic awHave;
		logic [31:0] awAddr;
		logic wHave;
		logic [31:0] wData;
		logic [3:0] wStrb;
		logic bValid;
		logic [1:0] bResp;
		logic rValid;
		logic [31:0] rData;
		logic [1:0] rResp;
		logic readSeen;
		logic must_be_one_bit;
		logic [3:0] txAlloc;
		logic timeoutFlag;
		hcr_soft_reset_trigger_t srState;
		logic [11:0] srCount;
		logic [1:0] irqStatus;
		logic [1:0] irqEnable;
		logic xover;
		hcr_bytes_t txDataBytes;
		hcr_bytes_t rxStatusBytes;
		hcr_bytes_t rxDataBytes;
	} hcr_state_t;

	typedef struct packed {
		logic [3:0] stage1;
		logic [3:0] stage2;
	} hcr_sync_state_t;

endpackage

`default_nettype wire

// file: rtl/hcr_sync.sv
`timescale 1ns/1ps
`default_nettype none

module hcr_sync (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Asynchronous levels in, synchronised levels out
	input wire logic [3:0] async,
	output logic [3:0] synced
);
	import hcr_pkg::*;

	hcr_sync_state_t s;
	hcr_sync_state_t next_s;

	// First stage feeds only the second stage
	always_comb begin
		next_s.stage1 = async;
		next_s.stage2 = s.stage1;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
		end else begin
			s <= next_s;
		end
	end

	assign synced = s.stage2;

endmodule

`default_nettype wire

// file: rtl/hcr_top.sv
// How it works
// - Bit 24 reads the auto-crossover strap level; writes ignored.
// - Two PHY bits may override the strap for the effective crossover.
// - Bits 19:16 hold transmit allocation in kilobytes, reset five.
// - 512 bytes of transmit allocation go to status, rest to data.
// - Receive side gets 16 kB minus the transmit allocation.
// - Bit 2 reads the bus-width strap: one 32-bit, zero 16-bit.
// - Soft reset without PHY clocks times out and sets bit 1.
// - Writing one to bit 0 starts soft reset; clears when done.
// - Soft reset resets MAC and system registers except exempt bits.
// - Soft reset also clears latched transmit and receive errors.
// - One read is needed after any reset or wake before writes act.
`include "hcr_map.svh"
`timescale 1ns/1ps
`default_nettype none

module hcr_top (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// AXI4-Lite write address
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	// AXI4-Lite write data
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	// AXI4-Lite write response
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	// AXI4-Lite read address
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	// AXI4-Lite read data
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Strap pins
	input wire logic autoCrossoverStrap,
	input wire logic busWidthStrap,
	// PHY state
	input wire logic phyRxClkRunning,
	input wire logic phyTxClkRunning,
	input wire logic phyXoverOverride,
	input wire logic phyXoverValue,
	// Power management
	input wire logic powerSaveExit,
	// Effective crossover and configuration
	output logic autoCrossoverEnable,
	output logic mustBeOneBit,
	output logic [3:0] txFifoAllocation,
	output hcr_pkg::hcr_bytes_t txDataBytes,
	output hcr_pkg::hcr_bytes_t txStatusBytes,
	output hcr_pkg::hcr_bytes_t rxDataBytes,
	output hcr_pkg::hcr_bytes_t rxStatusBytes,
	// Soft reset to the rest of the controller
	output logic macCsrReset,
	output logic sysCsrReset,
	output logic errorClear,
	// Interrupt
	output logic irq
);
	import hcr_pkg::*;

	localparam int CLK_NS = `HCR_CLK_PERIOD_NS;
	localparam int TIMEOUT_CYC = (`HCR_SOFT_RESET_TRIGGER_TIMEOUT_NS + CLK_NS - 1) / CLK_NS;
	localparam int PULSE_CYC = (`HCR_SOFT_RESET_TRIGGER_PULSE_NS + CLK_NS - 1) / CLK_NS;
	localparam logic [11:0] TIMEOUT_LAST = 12'(TIMEOUT_CYC - 1);
	localparam logic [11:0] PULSE_LAST = 12'(PULSE_CYC - 1);

	hcr_state_t s;
	hcr_state_t next_s;
	logic [3:0] synced;
	logic xoverStrapSync;
	logic busWidthSync;
	logic phyClocksOk;
	logic wrFire;
	logic rdFire;
	logic wrHwcfg;
	logic rdHwcfg;
	logic [31:0] hwcfgValue;
	logic [14:0] txTotal;

	// Straps and PHY clock indications come from outside this clock
	hcr_sync u_sync (
		.sys_clk(sys_clk),
		.rst_n(rst_n),
		.async({phyTxClkRunning, phyRxClkRunning, busWidthStrap, autoCrossoverStrap}),
		.synced(synced)
	);

	assign xoverStrapSync = synced[0];
	assign busWidthSync = synced[1];
	assign phyClocksOk = synced[2] & synced[3];

	assign wrFire = s.awHave & s.wHave & ~s.bValid;
	assign rdFire = s_axi_arvalid & s_axi_arready;
	assign wrHwcfg = wrFire & (s.awAddr == `HCR_HWCFG_OFFSET);
	assign rdHwcfg = rdFire & (s_axi_araddr == `HCR_HWCFG_OFFSET);

	// Bit 0 reads one for as long as the reset sequence runs
	always_comb begin
		hwcfgValue = '0;
		hwcfgValue[`HCR_XOVER_STRAP_BIT] = xoverStrapSync;
		hwcfgValue[`HCR_MBO_BIT] = s.must_be_one_bit;
		hwcfgValue[`HCR_ALLOC_MSB:`HCR_ALLOC_LSB] = s.txAlloc;
		hwcfgValue[`HCR_BUS_WIDTH_BIT] = busWidthSync;
		hwcfgValue[`HCR_TIMEOUT_BIT] = s.timeoutFlag;
		hwcfgValue[`HCR_SOFT_RESET_TRIGGER_BIT] = (s.srState != SR_IDLE);
	end

	always_comb begin
		next_s = s;
		txTotal = '0;
		if (s_axi_awvalid && s_axi_awready) begin
			next_s.awHave = 1'b1;
			next_s.awAddr = s_axi_awaddr;
		end
		if (s_axi_wvalid && s_axi_wready) begin
			next_s.wHave = 1'b1;
			next_s.wData = s_axi_wdata;
			next_s.wStrb = s_axi_wstrb;
		end
		if (s.bValid && s_axi_bready) begin
			next_s.bValid = 1'b0;
		end
		if (s.rValid && s_axi_rready) begin
			next_s.rValid = 1'b0;
		end

		// A wake from power saving demands a fresh read
		if (powerSaveExit) begin
			next_s.readSeen = 1'b0;
		end

		if (rdFire) begin
			next_s.rValid = 1'b1;
			next_s.rResp = `HCR_RESP_OKAY;
			next_s.rData = '0;
			next_s.readSeen = 1'b1;
			if (s_axi_araddr == `HCR_HWCFG_OFFSET) begin
				next_s.rData = hwcfgValue;
			end else if (s_axi_araddr == `HCR_IRQ_STATUS_OFFSET) begin
				next_s.rData[`HCR_IRQ_WIDTH-1:0] = s.irqStatus;
			end else if (s_axi_araddr == `HCR_IRQ_ENABLE_OFFSET) begin
				next_s.rData[`HCR_IRQ_WIDTH-1:0] = s.irqEnable;
			end else if (s_axi_araddr == `HCR_IRQ_CLEAR_OFFSET) begin
				next_s.rData = '0;
			end else begin
				next_s.rResp = `HCR_RESP_DECERR;
			end
		end

		// Writes before the first read are answered but dropped
		if (wrFire) begin
			next_s.awHave = 1'b0;
			next_s.wHave = 1'b0;
			next_s.bValid = 1'b1;
			next_s.bResp = `HCR_RESP_OKAY;
			if (s.awAddr == `HCR_HWCFG_OFFSET) begin
				if (s.readSeen && s.wStrb[2]) begin
					next_s.must_be_one_bit = s.wData[`HCR_MBO_BIT];
					next_s.txAlloc = s.wData[`HCR_ALLOC_MSB:`HCR_ALLOC_LSB];
				end
				if (s.readSeen && s.wStrb[0] && s.wData[`HCR_SOFT_RESET_TRIGGER_BIT]
					&& s.srState == SR_IDLE) begin
					next_s.srState = SR_WAIT;
					next_s.srCount = '0;
					next_s.timeoutFlag = 1'b0;
				end
			end else if (s.awAddr == `HCR_IRQ_CLEAR_OFFSET) begin
				if (s.readSeen && s.wStrb[0]) begin
					next_s.irqStatus = s.irqStatus & ~s.wData[`HCR_IRQ_WIDTH-1:0];
				end
			end else if (s.awAddr == `HCR_IRQ_ENABLE_OFFSET) begin
				if (s.readSeen && s.wStrb[0]) begin
					next_s.irqEnable = s.wData[`HCR_IRQ_WIDTH-1:0];
				end
			end else if (s.awAddr != `HCR_IRQ_STATUS_OFFSET) begin
				next_s.bResp = `HCR_RESP_DECERR;
			end
		end

		// Soft reset sequence; event sets come after the clear so they win
		case (s.srState)
			SR_IDLE: begin
				next_s.srCount = s.srCount;
			end
			SR_WAIT: begin
				if (phyClocksOk) begin
					next_s.srState = SR_PULSE;
					next_s.srCount = '0;
				end else if (s.srCount == TIMEOUT_LAST) begin
					next_s.srState = SR_IDLE;
					next_s.timeoutFlag = 1'b1;
					next_s.irqStatus[`HCR_IRQ_TIMEOUT_BIT] = 1'b1;
				end else begin
					next_s.srCount = s.srCount + 12'h001;
				end
			end
			SR_PULSE: begin
				if (s.srCount == PULSE_LAST) begin
					next_s.srState = SR_IDLE;
					next_s.must_be_one_bit = `HCR_MBO_RESET;
					next_s.txAlloc = `HCR_ALLOC_RESET;
					next_s.readSeen = 1'b0;
					next_s.irqStatus[`HCR_IRQ_DONE_BIT] = 1'b1;
				end else begin
					next_s.srCount = s.srCount + 12'h001;
				end
			end
			default: begin
				next_s.srState = SR_IDLE;
			end
		endcase

		// PHY bits take precedence over the strap
		next_s.xover = phyXoverOverride ? phyXoverValue : xoverStrapSync;

		// Split of the shared memory, registered for timing
		txTotal = {1'b0, next_s.txAlloc, 10'h000};
		next_s.txDataBytes = txTotal - `HCR_TX_STATUS_BYTES;
		next_s.rxStatusBytes = (`HCR_TOTAL_BYTES - txTotal) >> 4;
		next_s.rxDataBytes = (`HCR_TOTAL_BYTES - txTotal) - next_s.rxStatusBytes;
	end

	always_ff @(posedge sys_clk or negedge rst_n) begin
		if (!rst_n) begin
			s <= '0;
			s.must_be_one_bit <= `HCR_MBO_RESET;
			s.txAlloc <= `HCR_ALLOC_RESET;
			s.srState <= SR_IDLE;
			s.txDataBytes <= {1'b0, `HCR_ALLOC_RESET, 10'h000} - `HCR_TX_STATUS_BYTES;
			s.rxStatusBytes <= (`HCR_TOTAL_BYTES - {1'b0, `HCR_ALLOC_RESET, 10'h000}) >> 4;
			s.rxDataBytes <= (`HCR_TOTAL_BYTES - {1'b0, `HCR_ALLOC_RESET, 10'h000})
				- ((`HCR_TOTAL_BYTES - {1'b0, `HCR_ALLOC_RESET, 10'h000}) >> 4);
		end else begin
			s <= next_s;
		end
	end

	// Ready terms: one transfer of each kind at a time
	assign s_axi_awready = ~s.awHave;
	assign s_axi_wready = ~s.wHave;
	assign s_axi_arready = ~s.rValid;
	assign s_axi_bvalid = s.bValid;
	assign s_axi_bresp = s.bResp;
	assign s_axi_rvalid = s.rValid;
	assign s_axi_rdata = s.rData;
	assign s_axi_rresp = s.rResp;

	assign autoCrossoverEnable = s.xover;
	assign mustBeOneBit = s.must_be_one_bit;
	assign txFifoAllocation = s.txAlloc;
	assign txDataBytes = s.txDataBytes;
	assign txStatusBytes = `HCR_TX_STATUS_BYTES;
	assign rxDataBytes = s.rxDataBytes;
	assign rxStatusBytes = s.rxStatusBytes;

	// One reset pulse clears registers and latched errors alike
	assign macCsrReset = (s.srState == SR_PULSE);
	assign sysCsrReset = (s.srState == SR_PULSE);
	assign errorClear = (s.srState == SR_PULSE);

	assign irq = |(s.irqStatus & s.irqEnable);

	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (!rst_n);

	sequence srstRequest;
		wrHwcfg && s.readSeen && s.wStrb[0] && s.wData[0] && s.srState == SR_IDLE;
	endsequence

	sequence resetPulse;
		macCsrReset [*8] ##1 !macCsrReset;
	endsequence

	strap_readback_a: assert property (rdHwcfg |=> s_axi_rdata[24] == $past(xoverStrapSync))
		else $error("Crossover strap not reported in bit 24");

	xover_override_a: assert property (
		phyXoverOverride |=> autoCrossoverEnable == $past(phyXoverValue))
		else $error("PHY override of crossover ignored");

	alloc_write_a: assert property (
		wrHwcfg && s.readSeen && s.wStrb[2] && s.srState != SR_PULSE
		|=> txFifoAllocation == $past(s.wData[19:16]))
		else $error("Transmit allocation write lost");

	tx_split_a: assert property (txDataBytes + txStatusBytes == {1'b0, txFifoAllocation, 10'h000})
		else $error("Transmit split does not match allocation");

	rx_split_a: assert property (
		rxDataBytes + rxStatusBytes + {1'b0, txFifoAllocation, 10'h000} == 15'h4000)
		else $error("Receive share is not the remainder");

	bus_width_a: assert property (rdHwcfg |=> s_axi_rdata[2] == $past(busWidthSync))
		else $error("Bus width strap not reported in bit 2");

	soft_reset_trigger_timeout_a: assert property (
		s.srState == SR_WAIT && s.srCount == TIMEOUT_LAST && !phyClocksOk
		|=> s.timeoutFlag && s.srState == SR_IDLE && !macCsrReset)
		else $error("Soft reset timeout not flagged");

	soft_reset_trigger_sequence_a: assert property (
		srstRequest ##1 phyClocksOk |=> resetPulse ##0 s.srState == SR_IDLE)
		else $error("Soft reset pulse wrong length");

	error_clear_a: assert property (macCsrReset |-> errorClear && sysCsrReset)
		else $error("Errors not cleared with soft reset");

	no_write_before_read_a: assert property (
		wrHwcfg && !s.readSeen && s.srState != SR_PULSE |=> $stable(txFifoAllocation) && $stable(mustBeOneBit))
		else $error("Write acted before first read");

	reserved_zero_a: assert property (rdHwcfg |=> (s_axi_rdata & `HCR_RSVD_MASK) == 32'h0000_0000)
		else $error("Reserved bits read nonzero");

	soft_reset_trigger_readback_a: assert property (
		s.srState == SR_PULSE && s.srCount == PULSE_LAST |=> txFifoAllocation == 4'h5 && !mustBeOneBit)
		else $error("Soft reset did not restore configuration");

	// Done event must reach the pin in the same cycle that it is latched
	irq_level_a: assert property (
		s.srState == SR_PULSE && s.srCount == PULSE_LAST && s.irqEnable[0] && !wrFire |=> irq)
		else $error("Interrupt level wrong");

endmodule

`default_nettype wire

// file: verification/hcr_host.sv
`timescale 1ns/1ps
`default_nettype none

module hcr_host (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst_n,
	// Write address and data
	output logic [31:0] awaddr,
	output logic awvalid,
	input wire logic awready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	output logic wvalid,
	input wire logic wready,
	// Write response
	input wire logic [1:0] bresp,
	input wire logic bvalid,
	output logic bready,
	// Read channels
	output logic [31:0] araddr,
	output logic arvalid,
	input wire logic arready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp,
	input wire logic rvalid,
	output logic rready
);
	initial begin
		awaddr = 32'h0;
		awvalid = 1'b0;
		wdata = 32'h0;
		wstrb = 4'h0;
		wvalid = 1'b0;
		bready = 1'b0;
		araddr = 32'h0;
		arvalid = 1'b0;
		rready = 1'b0;
	end

	// Caller keeps traffic halted around writes
	// Handshakes sampled at the falling edge, acted on at the next rising edge
	task automatic write(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [1:0] resp);
		logic aHs, wHs, bHs;
		bHs = 1'b0;
		resp = 2'h0;
		wait (rst_n === 1'b1);
		@(posedge sys_clk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wstrb <= s;
		wvalid <= 1'b1;
		bready <= 1'b1;
		// Waits for the answer; only the bench watchdog ends a hang
		while (!bHs) begin
			@(negedge sys_clk);
			aHs = awvalid && awready;
			wHs = wvalid && wready;
			bHs = bvalid && bready;
			resp = bresp;
			@(posedge sys_clk);
			// Released lines show the inverse, never a stale copy
			if (aHs) begin
				awvalid <= 1'b0;
				awaddr <= ~a;
			end
			if (wHs) begin
				wvalid <= 1'b0;
				wdata <= ~d;
				wstrb <= ~s;
			end
		end
		bready <= 1'b0;
	endtask

	task automatic read(input logic [31:0] a, output logic [31:0] d, output logic [1:0] resp);
		logic arHs, rHs;
		rHs = 1'b0;
		d = 32'h0;
		resp = 2'h0;
		wait (rst_n === 1'b1);
		@(posedge sys_clk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		while (!rHs) begin
			@(negedge sys_clk);
			arHs = arvalid && arready;
			rHs = rvalid && rready;
			d = rdata;
			resp = rresp;
			@(posedge sys_clk);
			if (arHs) begin
				arvalid <= 1'b0;
				araddr <= ~a;
			end
		end
		rready <= 1'b0;
	endtask
endmodule

`default_nettype wire

// file: verification/hcr_top_tb.sv
`include "hcr_map.svh"
`timescale 1ns/1ps
`default_nettype none

module hcr_top_tb;
	import hcr_pkg::*;
	localparam logic [31:0] CFG = `HCR_HWCFG_OFFSET;
	localparam logic [31:0] IST = `HCR_IRQ_STATUS_OFFSET;
	localparam logic [31:0] ICL = `HCR_IRQ_CLEAR_OFFSET;
	localparam logic [31:0] IEN = `HCR_IRQ_ENABLE_OFFSET;
	logic sys_clk = 1'b0;
	logic rst_n = 1'b0;
	logic [31:0] awaddr, wdata, araddr, rdata;
	logic [3:0] wstrb, txFifoAllocation;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic xStrap = 1'b1;
	logic bwStrap = 1'b0;
	logic rxRun = 1'b1;
	logic txRun = 1'b1;
	logic ovr = 1'b0;
	logic ovrVal = 1'b0;
	logic psExit = 1'b0;
	logic autoCrossoverEnable, mustBeOneBit, macCsrReset, sysCsrReset, errorClear, irq;
	hcr_bytes_t txDataBytes, txStatusBytes, rxDataBytes, rxStatusBytes;
	int n_fail = 0;
	int checked = 0;
	int nMac = 0;
	int nSys = 0;
	int nErr = 0;

	always #2 sys_clk = ~sys_clk;

	hcr_top i_hcr_top (.sys_clk(sys_clk), .rst_n(rst_n),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
		.s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
		.s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
		.s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
		.autoCrossoverStrap(xStrap), .busWidthStrap(bwStrap),
		.phyRxClkRunning(rxRun), .phyTxClkRunning(txRun),
		.phyXoverOverride(ovr), .phyXoverValue(ovrVal), .powerSaveExit(psExit),
		.autoCrossoverEnable(autoCrossoverEnable), .mustBeOneBit(mustBeOneBit),
		.txFifoAllocation(txFifoAllocation), .txDataBytes(txDataBytes),
		.txStatusBytes(txStatusBytes), .rxDataBytes(rxDataBytes), .rxStatusBytes(rxStatusBytes),
		.macCsrReset(macCsrReset), .sysCsrReset(sysCsrReset), .errorClear(errorClear),
		.irq(irq));

	hcr_host i_hcr_host (.sys_clk(sys_clk), .rst_n(rst_n),
		.awaddr(awaddr), .awvalid(awvalid), .awready(awready),
		.wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
		.bresp(bresp), .bvalid(bvalid), .bready(bready),
		.araddr(araddr), .arvalid(arvalid), .arready(arready),
		.rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

	// Pulse lengths counted away from the launching edge
	always @(negedge sys_clk) begin
		if (macCsrReset === 1'b1) nMac++;
		if (sysCsrReset === 1'b1) nSys++;
		if (errorClear === 1'b1) nErr++;
	end

	task automatic report_and_stop;
		$display("Comparisons %0d, mismatches %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
		checked++;
		if (seen !== exp) begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", what, exp, seen);
		end
	endtask

	function automatic logic [31:0] cfg(input logic m, input logic [3:0] v, input logic t);
		return {7'h0, xStrap, 3'h0, m, v, 13'h0, bwStrap, t, 1'b0};
	endfunction

	task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s);
		logic [1:0] r;
		i_hcr_host.write(a, d, s, r);
	endtask

	task automatic rd(input logic [31:0] a, output logic [31:0] d);
		logic [1:0] r;
		i_hcr_host.read(a, d, r);
	endtask

	// Reads until the masked bits match, bounded
	task automatic poll(input logic [31:0] m, input logic [31:0] v, input int n,
		output logic [31:0] d);
		int i;
		i = 0;
		do begin
			rd(CFG, d);
			i++;
		end while ((d & m) !== v && i < n);
	endtask

	task automatic settle(input int n);
		repeat (n) @(posedge sys_clk);
		@(negedge sys_clk);
	endtask

	task automatic t_lock;
		logic [31:0] d;
		wr(CFG, 32'h0016_0000, 4'hf);
		rd(CFG, d);
		chk("cfg after reset", d, cfg(1'b0, 4'h5, 1'b0));
		chk("txData reset", txDataBytes, 32'd4608);
		wr(CFG, 32'h0013_0000, 4'hb);
		rd(CFG, d);
		chk("cfg strobe off", d, cfg(1'b0, 4'h5, 1'b0));
		wr(CFG, 32'h0013_0000, 4'h4);
		rd(CFG, d);
		chk("cfg mbo set", d, cfg(1'b1, 4'h3, 1'b0));
		chk("mbo out", mustBeOneBit, 32'h1);
		@(posedge sys_clk);
		psExit <= 1'b1;
		@(posedge sys_clk);
		psExit <= 1'b0;
		wr(CFG, 32'h0018_0000, 4'hf);
		rd(CFG, d);
		chk("cfg after wake", d, cfg(1'b1, 4'h3, 1'b0));
	endtask

	task automatic t_alloc;
		logic [31:0] d;
		int tot;
		// Only the legal settings are offered
		for (int v = 2; v <= 14; v++) begin
			wr(CFG, 32'hfff0_fffe | 32'(v << 16), 4'hf);
			rd(CFG, d);
			tot = v * 1024;
			chk("cfg alloc", d, cfg(1'b1, v[3:0], 1'b0));
			chk("alloc out", txFifoAllocation, v);
			chk("txData", txDataBytes, tot - 512);
			chk("txStatus", txStatusBytes, 32'd512);
			chk("rxStatus", rxStatusBytes, (16384 - tot) / 16);
			chk("rxData", rxDataBytes, (16384 - tot) - (16384 - tot) / 16);
		end
	endtask

	task automatic t_strap;
		logic [31:0] d;
		@(posedge sys_clk);
		xStrap <= 1'b0;
		bwStrap <= 1'b1;
		settle(5);
		rd(CFG, d);
		chk("cfg straps", d, cfg(1'b1, 4'he, 1'b0));
		chk("xover follows", autoCrossoverEnable, 32'h0);
		@(posedge sys_clk);
		ovr <= 1'b1;
		ovrVal <= 1'b1;
		settle(2);
		chk("xover forced on", autoCrossoverEnable, 32'h1);
		@(posedge sys_clk);
		ovrVal <= 1'b0;
		xStrap <= 1'b1;
		settle(5);
		chk("xover forced off", autoCrossoverEnable, 32'h0);
		rd(CFG, d);
		chk("strap bit", d[24], 32'h1);
		@(posedge sys_clk);
		ovr <= 1'b0;
	endtask

	task automatic t_soft_reset_trigger;
		logic [31:0] d;
		nMac = 0;
		nSys = 0;
		nErr = 0;
		wr(CFG, 32'h0019_0001, 4'hf);
		rd(CFG, d);
		chk("soft_reset_trigger running", d[0], 32'h1);
		poll(32'h1, 32'h0, 20, d);
		chk("cfg after soft_reset_trigger", d, cfg(1'b0, 4'h5, 1'b0));
		chk("mac reset len", nMac, 32'd8);
		chk("sys reset len", nSys, 32'd8);
		chk("error clear len", nErr, 32'd8);
		wr(IEN, 32'h1, 4'hf);
		settle(1);
		chk("irq raised", irq, 32'h1);
		wr(IEN, 32'h0, 4'hf);
		settle(1);
		chk("irq masked", irq, 32'h0);
		rd(IST, d);
		chk("status done", d, 32'h1);
		wr(IEN, 32'h1, 4'hf);
		wr(ICL, 32'h1, 4'hf);
		settle(1);
		chk("irq cleared", irq, 32'h0);
	endtask

	task automatic t_tmo;
		logic [31:0] d;
		@(posedge sys_clk);
		rxRun <= 1'b0;
		txRun <= 1'b0;
		settle(4);
		nMac = 0;
		wr(CFG, 32'h0015_0001, 4'hf);
		poll(32'h2, 32'h2, 1200, d);
		chk("timeout flag", d[1], 32'h1);
		chk("no pulse", nMac, 32'd0);
		rd(IST, d);
		chk("status timeout", d[1], 32'h1);
		@(posedge sys_clk);
		rxRun <= 1'b1;
		txRun <= 1'b1;
		settle(4);
		wr(CFG, 32'h0015_0001, 4'hf);
		rd(CFG, d);
		chk("timeout cleared", d[1], 32'h0);
		poll(32'h1, 32'h0, 20, d);
		chk("retry pulse", nMac, 32'd8);
	endtask

	task automatic t_misc;
		logic [31:0] d;
		logic [1:0] r;
		i_hcr_host.read(32'h0000_0200, d, r);
		chk("unmapped rresp", r, 32'h3);
		i_hcr_host.write(32'h0000_0300, 32'hffff_ffff, 4'hf, r);
		chk("unmapped bresp", r, 32'h3);
	endtask

	// Mid-run reset: defaults return and the first write is dropped
	task automatic t_reset;
		logic [31:0] d;
		@(posedge sys_clk);
		rst_n <= 1'b0;
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		wr(CFG, 32'h001c_0000, 4'hf);
		rd(CFG, d);
		chk("cfg after second reset", d, cfg(1'b0, 4'h5, 1'b0));
		chk("mbo out after reset", mustBeOneBit, 32'h0);
		chk("txData after reset", txDataBytes, 32'd4608);
	endtask

	// Whole run is near 2800 cycles; limit is 50000
	initial begin
		#200000;
		n_fail++;
		$display("ERROR watchdog expected completion seen hang");
		report_and_stop();
	end

	initial begin
		repeat (3) @(posedge sys_clk);
		rst_n <= 1'b1;
		@(posedge sys_clk);
		t_lock();
		t_alloc();
		t_strap();
		t_soft_reset_trigger();
		t_tmo();
		t_misc();
		t_reset();
		report_and_stop();
	end
endmodule

`default_nettype wire
